// file: rtl/cfef_pkg.sv
package cfef_pkg;

  // register port geometry
  localparam int CFEF_ADDR_W = 8;
  localparam int CFEF_DATA_W = 8;

  // register offsets on the serial register port
  localparam logic [7:0] CFEF_OFS_FAULT_STATUS_A = 8'h20;
  localparam logic [7:0] CFEF_OFS_FAULT_STATUS_B = 8'h21;
  localparam logic [7:0] CFEF_OFS_EVENT_FLAGS_A = 8'h22;
  localparam logic [7:0] CFEF_OFS_EVENT_FLAGS_B = 8'h23;

  // values after reset
  localparam logic [7:0] CFEF_RST_REG = 8'h00;

  // fault_status_a field positions
  localparam int CFEF_FSA_FIRST_OVP = 0;

  // fault_status_b field positions
  localparam int CFEF_FSB_SYS_SHORT = 7;
  localparam int CFEF_FSB_SYS_OVP = 6;
  localparam int CFEF_FSB_TSHUT = 2;

  // event_flags_a field positions
  localparam int CFEF_EFA_ICL = 7;
  localparam int CFEF_EFA_VCL = 6;
  localparam int CFEF_EFA_WDOG = 5;
  localparam int CFEF_EFA_WEAK = 4;
  localparam int CFEF_EFA_PGOOD = 3;
  localparam int CFEF_EFA_IN2 = 2;
  localparam int CFEF_EFA_IN1 = 1;
  localparam int CFEF_EFA_BUS = 0;

  // event_flags_b field positions
  localparam int CFEF_EFB_CHG = 7;
  localparam int CFEF_EFB_ICO = 6;
  localparam int CFEF_EFB_BUS = 4;
  localparam int CFEF_EFB_DIE_THERMAL_REGULATION = 2;
  localparam int CFEF_EFB_BAT = 1;
  localparam int CFEF_EFB_BC12 = 0;

  // widths of multi-bit condition codes
  localparam int CFEF_CHG_W = 3;
  localparam int CFEF_ICO_W = 2;
  localparam int CFEF_BUS_W = 4;
  localparam int CFEF_BC12_W = 4;

  // live charger conditions, all asynchronous to the core clock
  typedef struct packed {
    logic first_input_overvoltage_status;
    logic system_rail_short_status;
    logic system_rail_overvoltage_status;
    logic thermal_shutdown_status;
    logic input_current_limiting;
    logic input_voltage_limiting;
    logic watchdog_expired;
    logic weak_source;
    logic power_good_status;
    logic second_input_present;
    logic first_input_present;
    logic main_input_present;
    logic [CFEF_CHG_W-1:0] charge_state;
    logic [CFEF_ICO_W-1:0] current_optimiser_state;
    logic [CFEF_BUS_W-1:0] main_input_bus_state;
    logic die_thermal_regulation;
    logic battery_present;
    logic [CFEF_BC12_W-1:0] adapter_detection_state;
  } cfef_cond_t;

  // register access request from the serial engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [CFEF_ADDR_W-1:0] addr;
  } cfef_req_t;

endpackage : cfef_pkg

// file: rtl/cfef_regs.sv
`timescale 1ns/1ps

// Behaviour
// RL1 - fault_status_a bit 0 follows live first-input overvoltage protection
// RL2 - fault_status_b bit 7 follows live system-rail short-circuit protection
// RL3 - fault_status_b bit 6 follows live system-rail overvoltage protection
// RL4 - fault_status_b bit 2 follows live die thermal shutdown
// RL5 - event_flags_a bit 7 sets on rising edge of input current limiting
// RL6 - event_flags_a bit 6 sets on rising edge of input voltage limiting
// RL7 - event_flags_a bit 5 sets on rising edge of watchdog expiry
// RL8 - event_flags_a bit 4 sets on rising edge of weak source status
// RL9 - event_flags_a bit 3 sets on any power-good status change
// RL10 - event_flags_a bit 2 sets on second input presence change
// RL11 - event_flags_a bit 1 sets on first input presence change
// RL12 - event_flags_a bit 0 sets on main input presence change
// RL13 - event_flags_b bit 7 sets on any charge state change
// RL14 - event_flags_b bit 6 sets on current optimiser status change
// RL15 - event_flags_b bit 4 sets on main input bus status change
// RL16 - event_flags_b bit 2 sets on rising thermal regulation crossing
// RL17 - event_flags_b bit 1 sets on battery presence change
// RL18 - event_flags_b bit 0 sets on adapter detection status change
// RL19 - flags stay set until their register is read; status bits are live
// RL20 - reserved bits read zero; writes change nothing
module cfef_regs (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire cfef_pkg::cfef_cond_t i_cond,
  input wire cfef_pkg::cfef_req_t i_req,
  output logic [cfef_pkg::CFEF_DATA_W-1:0] o_reg_rdata,
  output logic o_reg_ack
);
  import cfef_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // condition synchronisers

  cfef_cond_t sync1_q;
  cfef_cond_t sync2_q;
  cfef_cond_t prev_q;

  // two stages before any logic; prev holds last cycle's settled value
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= i_cond;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event detection

  // edge-type events only fire on assertion of the level
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise

  // change-type events fire on either direction of a single level
  function automatic logic flip(input logic now, input logic was);
    flip = now ^ was;
  endfunction : flip

  // change-type events on a code; narrower codes are widened by the caller
  function automatic logic moved(input logic [3:0] now, input logic [3:0] was);
    moved = now != was;
  endfunction : moved

  wire cfef_cond_t cur = sync2_q;
  wire cfef_cond_t old = prev_q;

  // event_flags_a edge sources: a level that stays high flags once only,
  // so a host that reads early is not flooded while limiting persists
  wire ev_icl = rise(cur.input_current_limiting, old.input_current_limiting); // [RL5]
  wire ev_vcl = rise(cur.input_voltage_limiting, old.input_voltage_limiting); // [RL6]
  wire ev_wdog = rise(cur.watchdog_expired, old.watchdog_expired); // [RL7]
  wire ev_weak = rise(cur.weak_source, old.weak_source); // [RL8]

  // presence and power-good report both arrival and loss
  wire ev_pgood = flip(cur.power_good_status, old.power_good_status); // [RL9]
  wire ev_in2 = flip(cur.second_input_present, old.second_input_present); // [RL10]
  wire ev_in1 = flip(cur.first_input_present, old.first_input_present); // [RL11]
  wire ev_bus = flip(cur.main_input_present, old.main_input_present); // [RL12]

  // event_flags_b code sources: compared whole, a multi-bit step counts once
  wire ev_chg = moved(4'(cur.charge_state), 4'(old.charge_state)); // [RL13]
  wire ev_ico = moved(4'(cur.current_optimiser_state),
                      4'(old.current_optimiser_state)); // [RL14]
  wire ev_main_input_bus = moved(4'(cur.main_input_bus_state), 4'(old.main_input_bus_state)); // [RL15]
  wire ev_bc12 = moved(4'(cur.adapter_detection_state),
                       4'(old.adapter_detection_state)); // [RL18]

  // thermal regulation only flags on entry; battery presence either way
  wire ev_die_thermal_regulation = rise(cur.die_thermal_regulation, old.die_thermal_regulation); // [RL16]
  wire ev_bat = flip(cur.battery_present, old.battery_present); // [RL17]

  logic [7:0] set_a;
  logic [7:0] set_b;

  // place each event at its field; positions not named stay zero [RL20]
  always_comb begin
    set_a = 8'h00;
    set_b = 8'h00;
    set_a[CFEF_EFA_ICL] = ev_icl; // [RL5]
    set_a[CFEF_EFA_VCL] = ev_vcl; // [RL6]
    set_a[CFEF_EFA_WDOG] = ev_wdog; // [RL7]
    set_a[CFEF_EFA_WEAK] = ev_weak; // [RL8]
    set_a[CFEF_EFA_PGOOD] = ev_pgood; // [RL9]
    set_a[CFEF_EFA_IN2] = ev_in2; // [RL10]
    set_a[CFEF_EFA_IN1] = ev_in1; // [RL11]
    set_a[CFEF_EFA_BUS] = ev_bus; // [RL12]
    set_b[CFEF_EFB_CHG] = ev_chg; // [RL13]
    set_b[CFEF_EFB_ICO] = ev_ico; // [RL14]
    set_b[CFEF_EFB_BUS] = ev_main_input_bus; // [RL15]
    set_b[CFEF_EFB_DIE_THERMAL_REGULATION] = ev_die_thermal_regulation; // [RL16]
    set_b[CFEF_EFB_BAT] = ev_bat; // [RL17]
    set_b[CFEF_EFB_BC12] = ev_bc12; // [RL18]
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  // one comparator shape for every offset
  function automatic logic addr_is(input logic [CFEF_ADDR_W-1:0] addr, input logic [7:0] ofs);
    addr_is = addr == ofs;
  endfunction : addr_is

  wire hit_fsa = addr_is(i_req.addr, CFEF_OFS_FAULT_STATUS_A);
  wire hit_fsb = addr_is(i_req.addr, CFEF_OFS_FAULT_STATUS_B);
  wire hit_efa = addr_is(i_req.addr, CFEF_OFS_EVENT_FLAGS_A);
  wire hit_efb = addr_is(i_req.addr, CFEF_OFS_EVENT_FLAGS_B);

  // only a read clears; a write to a flag register leaves it alone
  wire rd_efa = i_req.rd & hit_efa; // [RL19]
  wire rd_efb = i_req.rd & hit_efb; // [RL19]

  //////////////////////////////////////////////////////////////////////////////
  // sticky flag registers

  logic [7:0] flags_a_q;
  logic [7:0] flags_a_d;
  logic [7:0] flags_b_q;
  logic [7:0] flags_b_d;

  // read clears, but an event in the same cycle survives the clear
  assign flags_a_d = (rd_efa ? 8'h00 : flags_a_q) | set_a; // [RL19]
  assign flags_b_d = (rd_efb ? 8'h00 : flags_b_q) | set_b; // [RL19]

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_a_q <= CFEF_RST_REG;
      flags_b_q <= CFEF_RST_REG;
    end else begin
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // live fault status, no latching

  logic [7:0] fault_a;
  logic [7:0] fault_b;

  // status reads the synchronised level, two cycles behind the pin
  always_comb begin
    fault_a = 8'h00; // reserved positions stay zero [RL20]
    fault_b = 8'h00; // [RL20]
    fault_a[CFEF_FSA_FIRST_OVP] = cur.first_input_overvoltage_status; // [RL1]
    fault_b[CFEF_FSB_SYS_SHORT] = cur.system_rail_short_status; // [RL2]
    fault_b[CFEF_FSB_SYS_OVP] = cur.system_rail_overvoltage_status; // [RL3]
    fault_b[CFEF_FSB_TSHUT] = cur.thermal_shutdown_status; // [RL4]
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data mux and answer

  // unmapped offsets read zero; set_* never touch reserved bit positions
  wire [7:0] rd_mux = hit_fsa ? fault_a :
                      hit_fsb ? fault_b :
                      hit_efa ? flags_a_q :
                      hit_efb ? flags_b_q : 8'h00; // [RL20]

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic ack_q;
  logic ack_d;

  // data holds between reads so a slow host still sees the last answer
  assign rdata_d = i_req.rd ? rd_mux : rdata_q;
  assign ack_d = i_req.rd | i_req.wr; // [RL20]

  // writes are acknowledged but store nothing, every register here is read-only
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= CFEF_RST_REG;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_ack = ack_q;

endmodule : cfef_regs

// file: testbench/cfef_regs_props.sv
`timescale 1ns/1ps
module cfef_regs_props (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire cfef_pkg::cfef_cond_t i_cond,
  input wire cfef_pkg::cfef_req_t i_req,
  input wire logic [cfef_pkg::CFEF_DATA_W-1:0] o_reg_rdata,
  input wire logic o_reg_ack
);
  import cfef_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // decoded accesses
  wire req = i_req.rd | i_req.wr;
  wire rd20 = i_req.rd && i_req.addr == CFEF_OFS_FAULT_STATUS_A;
  wire rd21 = i_req.rd && i_req.addr == CFEF_OFS_FAULT_STATUS_B;
  wire rd22 = i_req.rd && i_req.addr == CFEF_OFS_EVENT_FLAGS_A;
  wire rdx = i_req.rd && (i_req.addr < 8'h20 || i_req.addr > 8'h23);
  logic arm_q;
  logic [3:0] cnt_q;
  // cycles icl has been high since a fresh rise, no read between
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      arm_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (rd22 || !i_cond.input_current_limiting) begin
      arm_q <= !rd22;
      cnt_q <= 4'h0;
    end else if (arm_q && cnt_q < 4'hf) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  chk_ack_follows: assert property (req |=> o_reg_ack) else $error("ack missing");
  chk_ack_idle: assert property (!req |=> !o_reg_ack) else $error("stray ack");
  chk_write_keeps: assert property (i_req.wr && !i_req.rd |=> $stable(o_reg_rdata))
    else $error("write changed data");
  chk_rsvd_zero: assert property (rd21 |=> (o_reg_rdata & 8'h3b) == 8'h00)
    else $error("reserved bit set");
  chk_fsa_rsvd: assert property (rd20 |=> o_reg_rdata[7:1] == 7'h00)
    else $error("reserved bit set");
  chk_unmapped_zero: assert property (rdx |=> o_reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  chk_tshut_live: assert property (i_cond.thermal_shutdown_status [*5] ##0 rd21
    |=> o_reg_rdata[2]) else $error("shutdown bit low");
  chk_flag_clears: assert property ($stable(i_cond) [*6] ##1 (rd22 && $stable(i_cond))
    ##1 (!i_req.rd && $stable(i_cond)) ##1 (rd22 && $stable(i_cond)) |=> o_reg_rdata == 8'h00)
    else $error("flags not cleared");
  chk_icl_rise: assert property (rd22 && arm_q && cnt_q >= 4'h6 |=> o_reg_rdata[7])
    else $error("icl flag missing");
  cover property (rd22 ##1 o_reg_rdata != 8'h00);
  cover property (i_req.wr);
  cover property (rd21 ##1 o_reg_rdata[2]);
endmodule : cfef_regs_props
bind cfef_regs cfef_regs_props chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_cond(i_cond), .i_req(i_req), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack));

// file: testbench/cfef_host.sv
`timescale 1ns/1ps
module cfef_host (
  input wire logic i_core_clk,
  input wire logic [cfef_pkg::CFEF_DATA_W-1:0] i_reg_rdata,
  input wire logic i_reg_ack,
  output cfef_pkg::cfef_req_t o_req
);
  import cfef_pkg::*;
  initial o_req = '0;
  // one strobe per access; ack waited for a bounded time only
  task automatic xfer(input bit w, input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 0;
    d = 8'h00;
    @(posedge i_core_clk);
    o_req <= {~w, w, a};
    @(posedge i_core_clk);
    o_req <= {2'b00, ~a}; // released address inverted, never a stale match
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_reg_ack === 1'b1) begin
        ok = 1;
        d = i_reg_rdata;
      end else @(posedge i_core_clk);
    end
  endtask : xfer
endmodule : cfef_host

// file: testbench/tb_charger_fault_event_flags.sv
`timescale 1ns/1ps
module tb_charger_fault_event_flags;
  import cfef_pkg::*;
  logic i_core_clk, i_sys_rst, o_reg_ack;
  cfef_cond_t i_cond, o, n, prv;
  cfef_req_t i_req;
  logic [7:0] o_reg_rdata, fa, fb, last;
  int err_total, checks, seed;
  initial begin
    i_core_clk = 0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  cfef_regs uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_cond(i_cond),
    .i_req(i_req), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack));
  cfef_host host (.i_core_clk(i_core_clk), .i_reg_rdata(o_reg_rdata),
    .i_reg_ack(o_reg_ack), .o_req(i_req));
  //////////////////////////////////////////////////////////////////////
  task results;
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask : cmp
  // model of the flag sets that one condition step o -> n must cause
  task automatic note_events(input cfef_cond_t o, input cfef_cond_t n);
    fa |= {~o.input_current_limiting & n.input_current_limiting,
      ~o.input_voltage_limiting & n.input_voltage_limiting,
      ~o.watchdog_expired & n.watchdog_expired, ~o.weak_source & n.weak_source,
      o.power_good_status ^ n.power_good_status,
      o.second_input_present ^ n.second_input_present,
      o.first_input_present ^ n.first_input_present,
      o.main_input_present ^ n.main_input_present};
    fb |= {o.charge_state != n.charge_state,
      o.current_optimiser_state != n.current_optimiser_state, 1'b0,
      o.main_input_bus_state != n.main_input_bus_state, 1'b0,
      ~o.die_thermal_regulation & n.die_thermal_regulation,
      o.battery_present ^ n.battery_present,
      o.adapter_detection_state != n.adapter_detection_state};
  endtask : note_events
  // model: live faults, read-clear flags, writes change nothing
  task automatic access(input bit w, input logic [7:0] a);
    logic [7:0] d, e;
    bit ok;
    host.xfer(w, a, d, ok);
    cmp("ack", 8'h01, {7'h00, ok});
    if (!ok) results();
    case (w ? 8'hff : a)
      8'h20: e = {7'h00, prv.first_input_overvoltage_status};
      8'h21: e = {prv.system_rail_short_status, prv.system_rail_overvoltage_status, 3'h0,
        prv.thermal_shutdown_status, 2'h0};
      8'h22: begin e = fa; fa = 8'h00; end
      8'h23: begin e = fb; fb = 8'h00; end
      8'hff: e = last;
      default: e = 8'h00;
    endcase
    cmp("rdata", e, d);
    last = e;
  endtask : access
  // random condition changes, each followed by reads
  initial begin
    seed = 41;
    err_total = 0;
    checks = 0;
    {fa, fb, last} = '0;
    i_sys_rst = 1;
    i_cond = '0;
    prv = '0;
    repeat (16) @(posedge i_core_clk);
    i_sys_rst <= 0;
    repeat (8) @(posedge i_core_clk);
    for (int a = 32; a < 36; a++) access(0, a[7:0]); // reset values
    for (int k = 0; k < 60; k++) begin
      if (k == 31) begin
        // mid-run reset with live levels: nonzero ones come back as fresh events
        @(posedge i_core_clk);
        i_sys_rst <= 1;
        repeat (16) @(posedge i_core_clk);
        i_sys_rst <= 0;
        {fa, fb, last} = '0;
        note_events('0, prv);
      end
      o = prv;
      n = (k % 2) ? $bits(cfef_cond_t)'($random(seed)) : prv;
      @(posedge i_core_clk);
      i_cond <= n;
      note_events(o, n);
      prv = n;
      repeat (8) @(posedge i_core_clk);
      access(k % 5 == 4, 8'h1e + 8'($random(seed) & 7));
      access(0, 8'h22);
      access(0, 8'h23);
    end
    results();
  end
endmodule : tb_charger_fault_event_flags
